// *** logic/lmp_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module lmp_ctrl
	import lmp_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic [4:0] cmd_op,
	input wire logic cmd_query,
	input wire logic [15:0] cmd_arg,
	input wire logic emission_active,
	input wire logic [15:0] head_temp_meas,
	input wire logic [15:0] pump_temp_meas,
	input wire logic [15:0] dbl_temp_meas,
	input wire logic [15:0] tri_temp_meas,
	input wire logic keyswitch_pin,
	input wire logic [7:0] aport_pin,
	output logic rsp_valid,
	output logic rsp_ok,
	output logic [15:0] rsp_data,
	output logic standby_active,
	output logic sleep_active,
	output logic pump_drive_en,
	output logic pump_standby,
	output logic qswitch_en,
	output logic pump_tec_en,
	output logic crystal_tec_en,
	output logic [15:0] pump_temp_target,
	output logic [15:0] dbl_temp_target,
	output logic [15:0] tri_temp_target,
	output logic [6:0] fan_duty,
	output logic [7:0] aport_drive,
	output logic [7:0] aport_active,
	output logic emit_permit,
	output logic warn_head_under,
	output logic warn_head_hot,
	output logic warn_sink_hot,
	output logic err_head_overtemp
);
	typedef struct packed {
		lmp_state_e state;
		lmp_param_s [NUM_SETS-1:0] sets;
		lmp_param_s cur;
		lmp_glob_s live;
		lmp_glob_s saved;
		logic [3:0] act_idx;
		logic service_ok;
		logic key_prev;
		logic key_armed;
		logic [7:0] aport_drive;
		logic [7:0] aport_active;
		logic err34;
		logic warn37;
		logic warn38;
		logic warn39;
		logic pump_en;
		logic pump_stby;
		logic qsw_en;
		logic tec_en;
		logic [6:0] fan_duty;
		logic emit_permit;
		logic rsp_valid;
		logic rsp_ok;
		logic [15:0] rsp_data;
	} lmp_core_s;

	lmp_core_s st_ff;
	lmp_core_s nxt_st;
	logic [SYNC_W-1:0] pin_lvl;
	logic key_lvl;
	logic [7:0] aport_lvl;

	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [15:0] flag16(input logic b);
		flag16 = {15'h0000, b};
	endfunction

	// Pins arrive from outside the clock domain
	lmp_pin_sync u_sync (
		.mclk(mclk),
		.reset(reset),
		.pin_async({keyswitch_pin, aport_pin}),
		.pin_level(pin_lvl)
	);

	assign key_lvl = pin_lvl[SYNC_W-1];
	assign aport_lvl = pin_lvl[7:0];

	always_comb begin
		logic blocked;
		logic ok;
		logic [15:0] data;
		logic [16:0] diff;
		blocked = 1'b0;
		ok = 1'b0;
		data = 16'h0000;
		diff = 17'h00000;
		nxt_st = st_ff;
		nxt_st.rsp_valid = 1'b0;
		nxt_st.rsp_ok = 1'b0;
		nxt_st.rsp_data = 16'h0000;

		// Boot applies the chosen user set with the saved globals
		if (st_ff.state == ST_BOOT) begin
			nxt_st.cur = st_ff.sets[st_ff.saved.boot_idx]; // [R08]
			nxt_st.act_idx = st_ff.saved.boot_idx;
			nxt_st.live = st_ff.saved;
			nxt_st.state = ST_RUN;
		end

		// Key must go off then on unless auto-start is set
		nxt_st.key_prev = key_lvl;
		if (!key_lvl) begin
			nxt_st.key_armed = 1'b0;
		end else if (!st_ff.key_prev) begin
			nxt_st.key_armed = 1'b1;
		end
		nxt_st.emit_permit = key_lvl && (st_ff.live.auto_start || st_ff.key_armed); // [R12]

		if (cmd_valid && (st_ff.state != ST_BOOT)) begin
			// Sleep drops everything but queries and the exit command
			blocked = (st_ff.state == ST_SLEEP) && !cmd_query
				&& !((cmd_op == OP_SLEEP) && (cmd_arg == ARG_OFF)); // [R06]
			if (!blocked) begin
				unique case (cmd_op)
					OP_STANDBY: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = flag16(st_ff.state == ST_STBY); // [R02]
						end else if (cmd_arg == ARG_ON) begin
							ok = 1'b1;
							nxt_st.state = ST_STBY; // [R01]
						end else if (cmd_arg == ARG_OFF) begin
							ok = 1'b1;
							nxt_st.state = ST_RUN; // [R02]
						end
					end
					OP_SLEEP: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = flag16(st_ff.state == ST_SLEEP); // [R04]
						end else if ((cmd_arg == ARG_ON) && !emission_active) begin
							ok = 1'b1;
							nxt_st.state = ST_SLEEP; // [R04] [R05]
						end else if ((cmd_arg == ARG_OFF) && !st_ff.err34) begin
							ok = 1'b1;
							if (st_ff.state == ST_SLEEP) begin
								nxt_st.state = ST_RUN; // [R04] [R20]
							end
						end
					end
					OP_SET_SAVE: begin
						if (!cmd_query && in_range(cmd_arg, USER_IDX_MIN, USER_IDX_MAX)) begin
							ok = 1'b1;
							nxt_st.sets[cmd_arg[3:0]] = st_ff.cur; // [R07]
							nxt_st.saved = st_ff.live; // [R09]
						end
					end
					OP_SET_RECALL: begin
						if (!cmd_query && in_range(cmd_arg, ARG_OFF, USER_IDX_MAX)) begin
							ok = 1'b1;
							nxt_st.cur = st_ff.sets[cmd_arg[3:0]]; // [R08] [R10]
							nxt_st.act_idx = cmd_arg[3:0];
						end
					end
					OP_ACTIVE_SET: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = {12'h000, st_ff.act_idx}; // [R10]
						end
					end
					OP_BOOT_SET: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = {12'h000, st_ff.live.boot_idx}; // [R11]
						end else if (in_range(cmd_arg, USER_IDX_MIN, USER_IDX_MAX)) begin
							ok = 1'b1;
							nxt_st.live.boot_idx = cmd_arg[3:0]; // [R11]
							nxt_st.saved.boot_idx = cmd_arg[3:0];
						end
					end
					OP_AUTO_START: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = flag16(st_ff.live.auto_start); // [R12]
						end else if (in_range(cmd_arg, ARG_OFF, ARG_ON)) begin
							ok = 1'b1;
							nxt_st.live.auto_start = cmd_arg[0]; // [R12]
						end
					end
					OP_APORT_LEVEL: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = {8'h00, aport_lvl}; // [R13]
						end else if (cmd_arg <= BYTE_MAX) begin
							ok = 1'b1;
							nxt_st.aport_drive = cmd_arg[7:0]; // [R13]
						end
					end
					OP_APORT_POL: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = {8'h00, st_ff.cur.polarity}; // [R14]
						end else if (cmd_arg <= BYTE_MAX) begin
							ok = 1'b1;
							nxt_st.cur.polarity = cmd_arg[7:0]; // [R14]
						end
					end
					OP_PUMP_SET: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = st_ff.cur.pump_set; // [R16]
						end else if (st_ff.service_ok && in_range(cmd_arg, PUMP_T_MIN, PUMP_T_MAX)) begin
							ok = 1'b1;
							nxt_st.cur.pump_set = cmd_arg; // [R15] [R16]
						end
					end
					OP_DBL_SET: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = st_ff.cur.dbl_set; // [R17]
						end else if (st_ff.service_ok && in_range(cmd_arg, XTAL_MIN, XTAL_MAX)) begin
							ok = 1'b1;
							nxt_st.cur.dbl_set = cmd_arg; // [R15] [R17]
						end
					end
					OP_TRI_SET: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = st_ff.cur.tri_set; // [R17]
						end else if (st_ff.service_ok && in_range(cmd_arg, XTAL_MIN, XTAL_MAX)) begin
							ok = 1'b1;
							nxt_st.cur.tri_set = cmd_arg; // [R15] [R17]
						end
					end
					OP_PUMP_READ, OP_DBL_READ, OP_TRI_READ, OP_HEAD_READ: begin
						ok = cmd_query; // [R15]
						if (cmd_op == OP_PUMP_READ) begin
							data = pump_temp_meas; // [R16]
						end else if (cmd_op == OP_DBL_READ) begin
							data = dbl_temp_meas; // [R17]
						end else if (cmd_op == OP_TRI_READ) begin
							data = tri_temp_meas;
						end else begin
							data = head_temp_meas; // [R18]
						end
					end
					OP_FAN_MODE: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = flag16(st_ff.cur.fan_mode); // [R21]
						end else if (in_range(cmd_arg, ARG_OFF, ARG_ON)) begin
							ok = 1'b1;
							nxt_st.cur.fan_mode = cmd_arg[0]; // [R21]
						end
					end
					OP_FAN_PCT: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = {9'h000, st_ff.cur.fan_pct}; // [R22]
						end else if (cmd_arg <= FAN_PCT_MAX) begin
							ok = 1'b1;
							nxt_st.cur.fan_pct = cmd_arg[6:0]; // [R22]
						end
					end
					OP_HEAD_SET: begin
						if (cmd_query) begin
							ok = 1'b1;
							data = st_ff.cur.head_set; // [R23]
						end else if (in_range(cmd_arg, HEAD_SET_MIN, HEAD_SET_MAX)) begin
							ok = 1'b1;
							nxt_st.cur.head_set = cmd_arg; // [R23]
						end
					end
					OP_SERVICE: begin
						if (!cmd_query && (cmd_arg == SERVICE_CODE)) begin
							ok = 1'b1;
							nxt_st.service_ok = 1'b1; // [R15]
						end
					end
					default: begin
						ok = 1'b0;
					end
				endcase
			end
			// Refusals leave every setting as it was
			nxt_st.rsp_valid = 1'b1; // [R24]
			nxt_st.rsp_ok = ok; // [R24]
			nxt_st.rsp_data = data;
		end

		// Head thermal supervision overrides any command in the same cycle
		nxt_st.warn37 = head_temp_meas < HEAD_UNDER; // [R18]
		nxt_st.warn39 = head_temp_meas > HEAD_OVER; // [R18]
		nxt_st.warn38 = (head_temp_meas > HEAD_WARN38) && !st_ff.err34;
		if (head_temp_meas > HEAD_SHUTDOWN) begin
			nxt_st.err34 = 1'b1; // [R19]
			nxt_st.warn38 = 1'b0; // [R19]
			nxt_st.state = ST_SLEEP; // [R19]
		end else if (st_ff.err34 && (head_temp_meas < HEAD_OVER)) begin
			nxt_st.err34 = 1'b0; // [R20]
		end

		// Standby keeps regulation, sleep stops pump, Q-switch and loops
		nxt_st.pump_en = nxt_st.state == ST_RUN;
		nxt_st.pump_stby = nxt_st.state == ST_STBY; // [R01]
		nxt_st.qsw_en = nxt_st.state != ST_SLEEP; // [R03]
		nxt_st.tec_en = nxt_st.state != ST_SLEEP; // [R03]

		// Active level per function, default active low
		nxt_st.aport_active = ~(aport_lvl ^ st_ff.cur.polarity); // [R14]

		// Control mode: one percent per tenth degree above setpoint
		if (!st_ff.cur.fan_mode) begin
			nxt_st.fan_duty = st_ff.cur.fan_pct; // [R22]
		end else begin
			diff = {1'b0, head_temp_meas} - {1'b0, st_ff.cur.head_set};
			if (diff[16]) begin
				nxt_st.fan_duty = 7'h00; // [R23]
			end else if (diff[15:0] > FAN_PCT_MAX) begin
				nxt_st.fan_duty = FAN_PCT_MAX[6:0]; // [R23]
			end else begin
				nxt_st.fan_duty = diff[6:0]; // [R23]
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_ff.state <= ST_BOOT;
			st_ff.sets <= {NUM_SETS{FACTORY_SET}};
			st_ff.cur <= FACTORY_SET;
			st_ff.live <= '{1'b0, BOOT_IDX_RST};
			st_ff.saved <= '{1'b0, BOOT_IDX_RST};
			st_ff.act_idx <= FACTORY_IDX;
			st_ff.service_ok <= 1'b0;
			st_ff.key_prev <= 1'b1;
			st_ff.key_armed <= 1'b0;
			st_ff.aport_drive <= 8'h00;
			st_ff.aport_active <= 8'h00;
			st_ff.err34 <= 1'b0;
			st_ff.warn37 <= 1'b0;
			st_ff.warn38 <= 1'b0;
			st_ff.warn39 <= 1'b0;
			st_ff.pump_en <= 1'b0;
			st_ff.pump_stby <= 1'b0;
			st_ff.qsw_en <= 1'b0;
			st_ff.tec_en <= 1'b0;
			st_ff.fan_duty <= 7'h00;
			st_ff.emit_permit <= 1'b0;
			st_ff.rsp_valid <= 1'b0;
			st_ff.rsp_ok <= 1'b0;
			st_ff.rsp_data <= 16'h0000;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rsp_valid = st_ff.rsp_valid;
	assign rsp_ok = st_ff.rsp_ok;
	assign rsp_data = st_ff.rsp_data;
	assign standby_active = st_ff.state[2];
	assign sleep_active = st_ff.state[3];
	assign pump_drive_en = st_ff.pump_en;
	assign pump_standby = st_ff.pump_stby;
	assign qswitch_en = st_ff.qsw_en;
	assign pump_tec_en = st_ff.tec_en;
	assign crystal_tec_en = st_ff.tec_en;
	assign pump_temp_target = st_ff.cur.pump_set;
	assign dbl_temp_target = st_ff.cur.dbl_set;
	assign tri_temp_target = st_ff.cur.tri_set;
	assign fan_duty = st_ff.fan_duty;
	assign aport_drive = st_ff.aport_drive;
	assign aport_active = st_ff.aport_active;
	assign emit_permit = st_ff.emit_permit;
	assign warn_head_under = st_ff.warn37;
	assign warn_head_hot = st_ff.warn38;
	assign warn_sink_hot = st_ff.warn39;
	assign err_head_overtemp = st_ff.err34;
endmodule
`default_nettype wire

// *** logic/lmp_pkg.sv ***
// Operation
// [R01] Standby command 1 drops pump current below threshold, temperatures stay regulated.
// [R02] Standby command 0 leaves standby; standby query answers 1 or 0.
// [R03] Sleep turns off pump, Q-switch, pump and crystal temperature loops.
// [R04] Sleep command 1 enters, 0 leaves; sleep query answers 1 or 0.
// [R05] Sleep entry is refused while laser emission is on.
// [R06] In sleep only queries and sleep-exit with 0 are obeyed.
// [R07] Ten user sets plus factory set; save 1..10 copies present parameters.
// [R08] A stored set is applied at boot and by command while running.
// [R09] Every save also stores the shared global parameters.
// [R10] Recall 1..10 applies a user set, 0 the factory set; query reports it.
// [R11] Boot select 1..10 picks the set for next boot; query returns it.
// [R12] Auto-start on/off, readable; when on with key on, no key cycle needed.
// [R13] Eight-bit analog port level byte; a 1 drives or reads the signal high.
// [R14] Polarity mask defaults active low; a 1 bit makes that function active high.
// [R15] Temperature set commands need service unlock; temperature queries always allowed.
// [R16] Pump setpoint 18.0 to 35.0 degrees; measured and commanded values readable.
// [R17] Crystal setpoints 100 to 4000 counts; measured and commanded counts readable.
// [R18] Head below 18 degrees warns 37, above 40 warns 39, operation continues.
// [R19] Head above 45 degrees forces sleep, clears warning 38, raises error 34.
// [R20] Head back below 40 degrees clears error 34 and allows sleep exit.
// [R21] Fan mode 0 is drive, 1 is temperature control; mode readable.
// [R22] Drive mode fan level is 0 to 100 percent of maximum, readable.
// [R23] Control mode regulates head temperature to setpoint 24.0 to 40.0 degrees.
// [R24] Out of range arguments are rejected and change nothing.
package lmp_pkg;
	localparam int NUM_SETS = 11;
	localparam logic [3:0] FACTORY_IDX = 4'h0;
	localparam logic [15:0] USER_IDX_MIN = 16'h0001;
	localparam logic [15:0] USER_IDX_MAX = 16'h000A;
	localparam logic [15:0] ARG_OFF = 16'h0000;
	localparam logic [15:0] ARG_ON = 16'h0001;
	localparam logic [15:0] BYTE_MAX = 16'h00FF;
	// Temperatures are tenths of a degree
	localparam logic [15:0] PUMP_T_MIN = 16'h00B4;
	localparam logic [15:0] PUMP_T_MAX = 16'h015E;
	localparam logic [15:0] HEAD_SET_MIN = 16'h00F0;
	localparam logic [15:0] HEAD_SET_MAX = 16'h0190;
	localparam logic [15:0] XTAL_MIN = 16'h0064;
	localparam logic [15:0] XTAL_MAX = 16'h0FA0;
	localparam logic [15:0] FAN_PCT_MAX = 16'h0064;
	localparam logic [15:0] HEAD_UNDER = 16'h00B4;
	localparam logic [15:0] HEAD_OVER = 16'h0190;
	localparam logic [15:0] HEAD_WARN38 = 16'h01AE;
	localparam logic [15:0] HEAD_SHUTDOWN = 16'h01C2;
	// Service access code, value arbitrary
	localparam logic [15:0] SERVICE_CODE = 16'h5A3C;
	// Factory set contents
	localparam logic [15:0] FAC_PUMP_T = 16'h00FA;
	localparam logic [15:0] FAC_XTAL = 16'h0672;
	localparam logic [6:0] FAC_FAN_PCT = 7'h32;
	localparam logic [15:0] FAC_HEAD_SET = 16'h014A;
	localparam logic [7:0] FAC_POLARITY = 8'h00;
	localparam logic [3:0] BOOT_IDX_RST = 4'h1;
	localparam int SYNC_W = 9;

	typedef enum logic [4:0] {
		OP_STANDBY = 5'h00, OP_SLEEP = 5'h01, OP_SET_SAVE = 5'h02, OP_SET_RECALL = 5'h03,
		OP_ACTIVE_SET = 5'h04, OP_BOOT_SET = 5'h05, OP_AUTO_START = 5'h06, OP_APORT_LEVEL = 5'h07,
		OP_APORT_POL = 5'h08, OP_PUMP_SET = 5'h09, OP_PUMP_READ = 5'h0A, OP_DBL_SET = 5'h0B,
		OP_DBL_READ = 5'h0C, OP_TRI_SET = 5'h0D, OP_TRI_READ = 5'h0E, OP_HEAD_READ = 5'h0F,
		OP_FAN_MODE = 5'h10, OP_FAN_PCT = 5'h11, OP_HEAD_SET = 5'h12, OP_SERVICE = 5'h13
	} lmp_op_e;

	typedef enum logic [3:0] {
		ST_BOOT = 4'b0001, ST_RUN = 4'b0010, ST_STBY = 4'b0100, ST_SLEEP = 4'b1000
	} lmp_state_e;

	typedef struct packed {
		logic [15:0] pump_set;
		logic [15:0] dbl_set;
		logic [15:0] tri_set;
		logic fan_mode;
		logic [6:0] fan_pct;
		logic [15:0] head_set;
		logic [7:0] polarity;
	} lmp_param_s;

	typedef struct packed {
		logic auto_start;
		logic [3:0] boot_idx;
	} lmp_glob_s;

	localparam lmp_param_s FACTORY_SET = '{FAC_PUMP_T, FAC_XTAL, FAC_XTAL, 1'b0, FAC_FAN_PCT,
		FAC_HEAD_SET, FAC_POLARITY};
endpackage

// *** logic/lmp_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module lmp_pin_sync
	import lmp_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [SYNC_W-1:0] pin_async,
	output logic [SYNC_W-1:0] pin_level
);
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		logic [SYNC_W-1:0] lvl;
	} lmp_sync_s;

	lmp_sync_s st_ff;
	lmp_sync_s nxt_st;

	// Stage one feeds only stage two
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pin_async;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.lvl = (st_ff.s2 & st_ff.s3) | (st_ff.lvl & (st_ff.s2 ^ st_ff.s3));
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pin_level = st_ff.lvl;
endmodule
`default_nettype wire

// *** test/lmp_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module lmp_host_model
	import lmp_pkg::*;
(
	input wire logic mclk,
	output logic cmd_valid,
	output logic [4:0] cmd_op,
	output logic cmd_query,
	output logic [15:0] cmd_arg,
	input wire logic rsp_valid,
	input wire logic rsp_ok,
	input wire logic [15:0] rsp_data
);
	initial begin
		cmd_valid = 1'h0;
		cmd_op = 5'h1F;
		cmd_query = 1'h0;
		cmd_arg = 16'h0000;
	end
	// Gap lets the host be slow; with no gap, commands are still taken only on every second edge
	task automatic send(input logic [4:0] op, input logic qry, input logic [15:0] arg, input int gap,
		output logic ok, output logic [15:0] data);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		#1;
		cmd_valid = 1'h1;
		cmd_op = op;
		cmd_query = qry;
		cmd_arg = arg;
		@(posedge mclk);
		#1;
		// Released fields inverted so stale values are never trusted
		cmd_valid = 1'h0;
		cmd_op = ~op;
		cmd_query = ~qry;
		cmd_arg = ~arg;
		ok = rsp_valid ? rsp_ok : 1'hx;
		data = rsp_data;
	endtask
endmodule
`default_nettype wire

// *** test/lmp_ctrl_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module lmp_ctrl_monitor
	import lmp_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic [4:0] cmd_op,
	input wire logic cmd_query,
	input wire logic [15:0] cmd_arg,
	input wire logic emission_active,
	input wire logic [15:0] head_temp_meas,
	input wire logic rsp_valid,
	input wire logic rsp_ok,
	input wire logic [15:0] rsp_data,
	input wire logic standby_active,
	input wire logic sleep_active,
	input wire logic pump_drive_en,
	input wire logic pump_standby,
	input wire logic qswitch_en,
	input wire logic pump_tec_en,
	input wire logic crystal_tec_en,
	input wire logic warn_head_under,
	input wire logic warn_head_hot,
	input wire logic warn_sink_hot,
	input wire logic err_head_overtemp
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// Boot cycle takes no command, so the edge after release is skipped
	sequence s_taken;
		cmd_valid && !$past(reset);
	endsequence
	sequence s_sleep_on;
		s_taken ##0 (cmd_op == OP_SLEEP && !cmd_query && cmd_arg == ARG_ON);
	endsequence
	// Answer reports the state at the taking edge; a shutdown may move it on the same edge
	chk_stby_query: assert property (
		s_taken ##0 (cmd_op == OP_STANDBY && cmd_query) |=> rsp_ok && rsp_data == {15'h0000, $past(standby_active)})
		else $error("standby query answer wrong");
	chk_sleep_query: assert property (
		s_taken ##0 (cmd_op == OP_SLEEP && cmd_query) |=> rsp_ok && rsp_data == {15'h0000, $past(sleep_active)})
		else $error("sleep query answer wrong");
	chk_stby_outputs: assert property (
		standby_active |-> pump_standby && !pump_drive_en && pump_tec_en && crystal_tec_en)
		else $error("standby outputs wrong");
	chk_sleep_outputs: assert property (
		sleep_active |-> !(pump_drive_en || qswitch_en || pump_tec_en || crystal_tec_en))
		else $error("sleep outputs wrong");
	chk_sleep_refused: assert property (
		s_sleep_on ##0 (emission_active && !sleep_active && head_temp_meas <= HEAD_SHUTDOWN)
		|=> rsp_valid && !rsp_ok && !sleep_active)
		else $error("sleep entered during emission");
	chk_sleep_ignores: assert property (
		s_taken ##0 (sleep_active && !cmd_query && cmd_op != OP_SLEEP) |=> rsp_valid && !rsp_ok && sleep_active)
		else $error("command obeyed in sleep");
	chk_hot_shutdown: assert property (
		(!$past(reset) && head_temp_meas > HEAD_SHUTDOWN) [*2] |-> sleep_active && err_head_overtemp && !warn_head_hot)
		else $error("no thermal shutdown");
	chk_err_clear: assert property (
		err_head_overtemp && head_temp_meas < HEAD_OVER |-> ##[1:2] !err_head_overtemp)
		else $error("overtemp error stuck");
	chk_warn_under: assert property (
		(head_temp_meas < HEAD_UNDER) [*3] |-> warn_head_under)
		else $error("undertemp warning missing");
	chk_warn_sink: assert property (
		(head_temp_meas > HEAD_OVER && head_temp_meas <= HEAD_SHUTDOWN) [*3] |-> warn_sink_hot)
		else $error("overtemp warning missing");
endmodule
bind lmp_ctrl lmp_ctrl_monitor lmp_ctrl_monitor_inst (.mclk, .reset, .cmd_valid, .cmd_op, .cmd_query, .cmd_arg,
	.emission_active, .head_temp_meas, .rsp_valid, .rsp_ok, .rsp_data, .standby_active, .sleep_active,
	.pump_drive_en, .pump_standby, .qswitch_en, .pump_tec_en, .crystal_tec_en, .warn_head_under,
	.warn_head_hot, .warn_sink_hot, .err_head_overtemp);
`default_nettype wire

// *** test/lmp_ctrl_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module lmp_ctrl_tb
	import lmp_pkg::*;
;
	logic mclk = 1'h0, reset = 1'h1, emission_active = 1'h0, keyswitch_pin = 1'h0, ok;
	logic cmd_valid, cmd_query, rsp_valid, rsp_ok, standby_active, sleep_active, pump_drive_en, pump_standby;
	logic qswitch_en, pump_tec_en, crystal_tec_en, emit_permit, warn_head_under, warn_head_hot, warn_sink_hot;
	logic err_head_overtemp;
	logic [4:0] cmd_op;
	logic [6:0] fan_duty;
	logic [7:0] aport_pin = 8'h00, aport_drive, aport_active;
	logic [15:0] cmd_arg, rsp_data, rd, pump_temp_target, dbl_temp_target, tri_temp_target;
	logic [15:0] head_temp_meas = 16'h012C, pump_temp_meas = 16'h00FB, dbl_temp_meas = 16'h0671;
	logic [15:0] tri_temp_meas = 16'h0673;
	int error_cnt = 0, n_tests = 0;
	always #10 mclk = ~mclk;
	lmp_ctrl lmp_ctrl_inst (.mclk, .reset, .cmd_valid, .cmd_op, .cmd_query, .cmd_arg, .emission_active,
		.head_temp_meas, .pump_temp_meas, .dbl_temp_meas, .tri_temp_meas, .keyswitch_pin, .aport_pin,
		.rsp_valid, .rsp_ok, .rsp_data, .standby_active, .sleep_active, .pump_drive_en, .pump_standby,
		.qswitch_en, .pump_tec_en, .crystal_tec_en, .pump_temp_target, .dbl_temp_target, .tri_temp_target,
		.fan_duty, .aport_drive, .aport_active, .emit_permit, .warn_head_under, .warn_head_hot,
		.warn_sink_hot, .err_head_overtemp);
	lmp_host_model lmp_host_model_inst (.mclk, .cmd_valid, .cmd_op, .cmd_query, .cmd_arg, .rsp_valid,
		.rsp_ok, .rsp_data);
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chb(input string what, input logic seen, input logic exp);
		chk(what, {15'h0000, seen}, {15'h0000, exp});
	endtask
	task automatic put(input lmp_op_e op, input logic [15:0] arg, input logic exp_ok);
		lmp_host_model_inst.send(op, 1'h0, arg, 0, ok, rd);
		chb(op.name(), ok, exp_ok);
	endtask
	task automatic ask(input lmp_op_e op, input logic [15:0] exp);
		lmp_host_model_inst.send(op, 1'h1, 16'h0000, 0, ok, rd);
		chb(op.name(), ok, 1'h1);
		chk(op.name(), rd, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic t_standby();
		put(OP_STANDBY, 16'h0001, 1'h1);
		chb("pump_standby", pump_standby, 1'h1);
		chb("pump_drive_en", pump_drive_en, 1'h0);
		ask(OP_STANDBY, 16'h0001);
		put(OP_STANDBY, 16'h0002, 1'h0);
		put(OP_STANDBY, 16'h0000, 1'h1);
		chb("pump_drive_en", pump_drive_en, 1'h1);
		ask(OP_STANDBY, 16'h0000);
		$display("standby test done");
	endtask
	task automatic t_sleep();
		emission_active = 1'h1;
		put(OP_SLEEP, 16'h0001, 1'h0);
		emission_active = 1'h0;
		put(OP_SLEEP, 16'h0001, 1'h1);
		chb("qswitch_en", qswitch_en, 1'h0);
		put(OP_FAN_PCT, 16'h000A, 1'h0);
		put(OP_STANDBY, 16'h0001, 1'h0);
		ask(OP_SLEEP, 16'h0001);
		put(OP_SLEEP, 16'h0000, 1'h1);
		chb("pump_tec_en", pump_tec_en, 1'h1);
		chk("fan_duty", {9'h000, fan_duty}, 16'h0032);
		ask(OP_SLEEP, 16'h0000);
		$display("sleep test done");
	endtask
	task automatic t_sets();
		ask(OP_ACTIVE_SET, 16'h0001);
		put(OP_FAN_PCT, 16'h0014, 1'h1);
		put(OP_SET_SAVE, 16'h000A, 1'h1);
		put(OP_FAN_PCT, 16'h0046, 1'h1);
		put(OP_SET_SAVE, 16'h000B, 1'h0);
		put(OP_SET_RECALL, 16'h000A, 1'h1);
		// Fan duty is registered from the applied set one edge later
		tick(1);
		chk("fan_duty", {9'h000, fan_duty}, 16'h0014);
		ask(OP_ACTIVE_SET, 16'h000A);
		put(OP_SET_RECALL, 16'h0000, 1'h1);
		tick(1);
		chk("fan_duty", {9'h000, fan_duty}, 16'h0032);
		put(OP_SET_RECALL, 16'h000B, 1'h0);
		put(OP_BOOT_SET, 16'h000A, 1'h1);
		put(OP_BOOT_SET, 16'h0000, 1'h0);
		ask(OP_BOOT_SET, 16'h000A);
		$display("parameter set test done");
	endtask
	task automatic t_auto();
		put(OP_AUTO_START, 16'h0001, 1'h1);
		ask(OP_AUTO_START, 16'h0001);
		chb("emit_permit", emit_permit, 1'h0);
		keyswitch_pin = 1'h1;
		tick(6);
		chb("emit_permit", emit_permit, 1'h1);
		put(OP_AUTO_START, 16'h0000, 1'h1);
		ask(OP_AUTO_START, 16'h0000);
		keyswitch_pin = 1'h0;
		tick(6);
		chb("emit_permit", emit_permit, 1'h0);
		keyswitch_pin = 1'h1;
		tick(6);
		chb("emit_permit", emit_permit, 1'h1);
		$display("auto start test done");
	endtask
	task automatic t_aport();
		chk("aport_active", {8'h00, aport_active}, 16'h00FF);
		put(OP_APORT_LEVEL, 16'h00A5, 1'h1);
		chk("aport_drive", {8'h00, aport_drive}, 16'h00A5);
		put(OP_APORT_POL, 16'h0100, 1'h0);
		put(OP_APORT_POL, 16'h0060, 1'h1);
		ask(OP_APORT_POL, 16'h0060);
		aport_pin = 8'h60;
		tick(6);
		chk("aport_active", {8'h00, aport_active}, 16'h00FF);
		ask(OP_APORT_LEVEL, 16'h0060);
		aport_pin = 8'h00;
		tick(6);
		chk("aport_active", {8'h00, aport_active}, 16'h009F);
		$display("analog port test done");
	endtask
	task automatic t_temps();
		put(OP_PUMP_SET, 16'h00FA, 1'h0);
		ask(OP_PUMP_READ, 16'h00FB);
		put(OP_SERVICE, SERVICE_CODE, 1'h1);
		put(OP_PUMP_SET, 16'h00B3, 1'h0);
		put(OP_PUMP_SET, 16'h015F, 1'h0);
		put(OP_PUMP_SET, 16'h00B4, 1'h1);
		chk("pump_target", pump_temp_target, 16'h00B4);
		ask(OP_PUMP_SET, 16'h00B4);
		put(OP_DBL_SET, 16'h0063, 1'h0);
		put(OP_DBL_SET, 16'h0FA0, 1'h1);
		chk("dbl_target", dbl_temp_target, 16'h0FA0);
		put(OP_TRI_SET, 16'h0064, 1'h1);
		chk("tri_target", tri_temp_target, 16'h0064);
		ask(OP_DBL_READ, 16'h0671);
		ask(OP_TRI_READ, 16'h0673);
		$display("temperature test done");
	endtask
	task automatic t_fan();
		ask(OP_FAN_MODE, 16'h0000);
		put(OP_FAN_PCT, 16'h0065, 1'h0);
		put(OP_FAN_PCT, 16'h0064, 1'h1);
		tick(1);
		chk("fan_duty", {9'h000, fan_duty}, 16'h0064);
		put(OP_FAN_MODE, 16'h0002, 1'h0);
		put(OP_HEAD_SET, 16'h00EF, 1'h0);
		put(OP_HEAD_SET, 16'h0104, 1'h1);
		put(OP_FAN_MODE, 16'h0001, 1'h1);
		tick(2);
		chk("fan_duty", {9'h000, fan_duty}, 16'h0028);
		put(OP_FAN_MODE, 16'h0000, 1'h1);
		tick(2);
		chk("fan_duty", {9'h000, fan_duty}, 16'h0064);
		$display("fan test done");
	endtask
	task automatic t_thermal();
		// Slow host: reply still comes one cycle after the late strobe
		lmp_host_model_inst.send(OP_HEAD_READ, 1'h1, 16'h0000, 3, ok, rd);
		chb("head_read_ok", ok, 1'h1);
		chk("head_read", rd, 16'h012C);
		head_temp_meas = 16'h00AA;
		tick(4);
		chb("warn_under", warn_head_under, 1'h1);
		head_temp_meas = 16'h019A;
		tick(4);
		chb("warn_sink", warn_sink_hot, 1'h1);
		head_temp_meas = 16'h01B8;
		tick(4);
		chb("warn_head_hot", warn_head_hot, 1'h1);
		head_temp_meas = 16'h01CC;
		tick(3);
		chb("err_overtemp", err_head_overtemp, 1'h1);
		chb("warn_head_hot", warn_head_hot, 1'h0);
		chb("sleep_active", sleep_active, 1'h1);
		put(OP_SLEEP, 16'h0000, 1'h0);
		head_temp_meas = 16'h0186;
		tick(3);
		chb("err_overtemp", err_head_overtemp, 1'h0);
		put(OP_SLEEP, 16'h0000, 1'h1);
		chb("sleep_active", sleep_active, 1'h0);
		$display("thermal test done");
	endtask
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	initial begin
		tick(16);
		reset = 1'h0;
		tick(3);
		t_standby();
		t_sleep();
		t_sets();
		t_auto();
		t_aport();
		t_temps();
		t_fan();
		t_thermal();
		stop_test();
	end
endmodule
`default_nettype wire
